// ==== src/dca_pkg.sv ====
// Package of constants shared by the serial attenuator control ends.
// Assumes nothing of its surroundings; both ends reference it by scope.
package dca_pkg;
  // ----------------------------------------------------------------
  // Word format
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int NUM_CHANNELS = 3;
  localparam logic [7:0] ADDR_CH1 = 8'h00;
  localparam logic [7:0] ADDR_CH2 = 8'h01;
  localparam logic [7:0] ADDR_CH3 = 8'h02;
  // Levels at or above this code mute the channel
  localparam logic [7:0] LEVEL_MUTE = 8'h4f;
  localparam logic [7:0] LEVEL_FINE_END = 8'h1f;
  localparam logic [7:0] LEVEL_MID_END = 8'h3f;
  // Attenuation in half dB steps at the base of the mid and coarse regions
  localparam logic [7:0] HALF_DB_MID_BASE = 8'h20;
  localparam logic [7:0] HALF_DB_COARSE_BASE = 8'h60;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  // Least setup of the strobe before the first shift edge
  localparam int STROBE_SETUP_NS = 150;
  localparam int STROBE_SETUP_CYC = (STROBE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host divides clk_in by twice this to make the shift clock
  localparam int SCLK_HALF_CYC = 4;
endpackage

// ==== src/dca_link_if.sv ====
// Three-wire serial link between controller and one attenuator.
// Assumes the bench chains devices by wiring data_out to the next data_in.
`timescale 1ns/1ps
interface dca_link_if;
  logic sclk;
  logic sdata;
  logic strobe;
  logic sdata_out;
  modport ctrl (output sclk, output sdata, output strobe, input sdata_out);
  modport dev (input sclk, input sdata, input strobe, output sdata_out);
endinterface

// ==== src/dca_device.sv ====
// Attenuator end: shift register on the link clock, latch and decode.
// Assumes sclk is made by the controller and idles low between frames;
// the strobe is sampled on sclk edges and at its own rising edge.
//
// Function
// - each channel keeps an independent level
// - chain shifts sixteen bits per device
// - controller lowers strobe, then clocks bits
// - old bits shift out toward next device
// - strobe rise latches every device together
// - decode address byte, apply level byte
// - one shared clock and strobe line
// - mute disconnects channel input from output
// - address byte first, MSB first
// - unknown address leaves channels unchanged
// - level 0x4f or above mutes channel
// - power-up mutes every channel
`timescale 1ns/1ps
module dca_device #(
  parameter int WORD_BITS = dca_pkg::WORD_BITS
) (
  input wire logic clk_in, // Core clock, 40 MHz
  input wire logic rst_n_in, // Async reset, power-up
  input wire logic clk_en_in, // Freezes core state when low
  dca_link_if.dev link, // Serial link, device side
  output logic [2:0] ch_mute_out, // Per-channel mute, input isolated
  output logic [2:0][7:0] ch_half_db_out, // Per-channel attenuation, 0.5 dB units
  output logic [7:0] ch1_level_out, // Raw level code, channel 1
  output logic [7:0] ch2_level_out, // Raw level code, channel 2
  output logic [7:0] ch3_level_out // Raw level code, channel 3
);
  // ----------------------------------------------------------------
  // Link-clock domain
  // ----------------------------------------------------------------
  // The latch runs on the strobe's own edge, so its registers live outside
  // the shift struct: one process may own a variable, never two.
  typedef struct packed {
    logic [WORD_BITS-1:0] shreg;
  } dca_link_st_t;

  dca_link_st_t ls;
  dca_link_st_t next_ls;
  logic [WORD_BITS-1:0] held;
  logic load_tgl;

  always_comb begin
    next_ls = ls;
    if (!link.strobe) begin
      next_ls.shreg = {ls.shreg[WORD_BITS-2:0], link.sdata};
    end
  end

  // Shifting happens on sclk; a clock enable cannot gate the link's own
  // clock, so the freeze applies to the core domain only.
  always_ff @(posedge link.sclk or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ls.shreg <= '0;
    end else begin
      ls.shreg <= next_ls.shreg;
    end
  end

  // Latch on the strobe's own rising edge so no sclk edge is needed after.
  always_ff @(posedge link.strobe or negedge rst_n_in) begin
    if (!rst_n_in) begin
      held <= '0;
      load_tgl <= 1'b0;
    end else begin
      held <= ls.shreg;
      load_tgl <= ~load_tgl;
    end
  end

  assign link.sdata_out = ls.shreg[WORD_BITS-1];

  // ----------------------------------------------------------------
  // Core domain: toggle crossing and decode
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] tgl_sync;
    logic [2:0] mute;
    logic [2:0][7:0] level;
    logic [2:0][7:0] half_db;
  } dca_core_st_t;

  dca_core_st_t cs;
  dca_core_st_t next_cs;
  logic [7:0] addr;
  logic [7:0] lvl;
  logic [7:0] lvl_half_db;

  assign addr = held[WORD_BITS-1 -: dca_pkg::BYTE_BITS];
  assign lvl = held[dca_pkg::BYTE_BITS-1:0];

  always_comb begin
    if (lvl <= dca_pkg::LEVEL_FINE_END) begin
      lvl_half_db = lvl;
    end else if (lvl <= dca_pkg::LEVEL_MID_END) begin
      lvl_half_db = 8'(dca_pkg::HALF_DB_MID_BASE + ((lvl - 8'h20) << 1));
    end else begin
      lvl_half_db = 8'(dca_pkg::HALF_DB_COARSE_BASE + ((lvl - 8'h40) << 2));
    end
  end

  always_comb begin
    next_cs = cs;
    next_cs.tgl_sync = {cs.tgl_sync[1:0], load_tgl};
    // Held word is stable long before the toggle settles through two stages
    if (cs.tgl_sync[2] != cs.tgl_sync[1]) begin
      for (int i = 0; i < dca_pkg::NUM_CHANNELS; i++) begin
        if (addr == 8'(i)) begin
          next_cs.level[i] = lvl;
          next_cs.mute[i] = (lvl >= dca_pkg::LEVEL_MUTE);
          next_cs.half_db[i] = lvl_half_db;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs.tgl_sync <= '0;
      cs.mute <= '1;
      cs.level <= {3{dca_pkg::LEVEL_MUTE}};
      cs.half_db <= '0;
    end else if (clk_en_in) begin
      cs <= next_cs;
    end
  end

  assign ch_mute_out = cs.mute;
  assign ch_half_db_out = cs.half_db;
  assign ch1_level_out = cs.level[0];
  assign ch2_level_out = cs.level[1];
  assign ch3_level_out = cs.level[2];
endmodule

// ==== src/dca_ctrl.sv ====
// Controller end: sends a chain of 16-bit words and pulses the strobe.
// Assumes user supplies words for all devices, last device's word first.
`timescale 1ns/1ps
module dca_ctrl #(
  parameter int CHAIN_LEN = 1,
  parameter int WORD_BITS = dca_pkg::WORD_BITS
) (
  input wire logic clk_in, // Core clock, 40 MHz
  input wire logic rst_n_in, // Async reset
  input wire logic clk_en_in, // Freezes all state when low
  input wire logic start_in, // Request one chain transfer
  input wire logic [CHAIN_LEN*WORD_BITS-1:0] words_in, // Chain image, MSB sent first
  output logic busy_out, // Transfer in progress
  output logic done_out, // One-cycle pulse at end of transfer
  dca_link_if.ctrl link // Serial link, controller side
);
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  localparam int TOTAL = CHAIN_LEN * WORD_BITS;
  typedef enum logic [1:0] {DCA_IDLE, DCA_SETUP, DCA_SHIFT, DCA_LOAD} dca_state_t;
  typedef struct packed {
    dca_state_t state;
    logic [TOTAL-1:0] sh;
    logic [15:0] bits;
    logic [7:0] div;
    logic sclk;
    logic strobe;
    logic done;
  } dca_ctrl_st_t;

  dca_ctrl_st_t s;
  dca_ctrl_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.state)
      DCA_IDLE: begin
        if (start_in) begin
          next_s.sh = words_in;
          next_s.strobe = 1'b0;
          next_s.div = 8'(dca_pkg::STROBE_SETUP_CYC);
          next_s.bits = 16'(TOTAL);
          next_s.state = DCA_SETUP;
        end
      end
      DCA_SETUP: begin
        if (s.div == 8'h00) begin
          next_s.div = 8'(dca_pkg::SCLK_HALF_CYC - 1);
          next_s.state = DCA_SHIFT;
        end else begin
          next_s.div = s.div - 8'h01;
        end
      end
      DCA_SHIFT: begin
        // Data changes with sclk low; device samples on the rising edge
        if (s.div == 8'h00) begin
          next_s.div = 8'(dca_pkg::SCLK_HALF_CYC - 1);
          if (!s.sclk) begin
            next_s.sclk = 1'b1;
          end else begin
            next_s.sclk = 1'b0;
            next_s.sh = {s.sh[TOTAL-2:0], 1'b0};
            next_s.bits = s.bits - 16'h0001;
            if (s.bits == 16'h0001) begin
              next_s.state = DCA_LOAD;
            end
          end
        end else begin
          next_s.div = s.div - 8'h01;
        end
      end
      DCA_LOAD: begin
        if (s.div == 8'h00) begin
          next_s.strobe = 1'b1;
          next_s.done = 1'b1;
          next_s.state = DCA_IDLE;
        end else begin
          next_s.div = s.div - 8'h01;
        end
      end
      default: begin
        next_s.state = DCA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s.state <= DCA_IDLE;
      s.sh <= '0;
      s.bits <= '0;
      s.div <= '0;
      s.sclk <= 1'b0;
      s.strobe <= 1'b1;
      s.done <= 1'b0;
    end else if (clk_en_in) begin
      s <= next_s;
    end
  end

  assign link.sclk = s.sclk;
  assign link.sdata = s.sh[TOTAL-1];
  assign link.strobe = s.strobe;
  assign busy_out = (s.state != DCA_IDLE);
  assign done_out = s.done;
endmodule

// ==== tb/dca_link_properties.sv ====
// Checker on the link between the controller and the first device.
// Assumes sclk is made from clk_in, so clk_in samples every link edge.
`timescale 1ns/1ps
module dca_link_properties #(
  parameter int CHAIN_LEN = 1
) (
  input logic clk_in, // Core clock
  input logic rst_n_in, // Async reset
  input logic sclk, // Shift clock
  input logic sdata, // Data from controller
  input logic strobe, // Load/shift strobe
  input logic sdata_out // First device data out
);
  logic [15:0] rises;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ------
  // Shift edges in the current frame
  // ------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) rises <= 16'h0;
    else if (strobe) rises <= 16'h0;
    else if ($rose(sclk)) rises <= rises + 16'h1;
  end
  chk_idle_low: assert property (strobe |-> !sclk)
    else $error("sclk outside frame");
  chk_setup_time: assert property ($fell(strobe) |-> !sclk [*6])
    else $error("strobe setup short");
  chk_high_half: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("sclk high phase");
  chk_low_half: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("sclk low phase");
  chk_data_hold: assert property (sclk |-> $stable(sdata))
    else $error("data moved while sclk high");
  chk_out_shift: assert property ($changed(sdata_out) |-> $rose(sclk) && !strobe)
    else $error("data out moved off a shift edge");
  chk_bit_count: assert property ($rose(strobe) |-> rises == 16'(16 * CHAIN_LEN))
    else $error("wrong bit count in frame");
  chk_latch_edge: assert property ($rose(strobe) |-> !$past(sclk))
    else $error("latch while sclk high");
endmodule

// ==== tb/daisy_chain_attenuator_serial_tb.sv ====
// Bench: controller driving a chain of two devices.
// Assumes words go far device first; channel 1 is bit 0 of each output.
`timescale 1ns/1ps
`define CK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module daisy_chain_attenuator_serial_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic clk_en = 1'b1;
  logic start_in = 1'b0;
  logic [31:0] words_in = 32'h0;
  logic busy_out;
  logic done_out;
  logic [2:0] mu [2];
  logic [2:0][7:0] hd [2];
  logic [2:0][7:0] raw [2];
  logic [7:0] lvl [2][3];
  logic [7:0] lv [8] = '{8'h00, 8'h1f, 8'h20, 8'h3f, 8'h40, 8'h4e, 8'h4f, 8'hff};
  int fails = 0;
  int checks_done = 0;
  dca_link_if l [2] ();
  always #12.5 clk_in = ~clk_in;
  assign l[1].sclk = l[0].sclk;
  assign l[1].strobe = l[0].strobe;
  assign l[1].sdata = l[0].sdata_out;
  dca_ctrl #(.CHAIN_LEN(2)) dca_ctrl_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .clk_en_in(clk_en), .start_in(start_in), .words_in(words_in), .busy_out(busy_out),
    .done_out(done_out), .link(l[0]));
  for (genvar d = 0; d < 2; d++) begin : g_dev
    dca_device dca_device_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en),
      .link(l[d]), .ch_mute_out(mu[d]), .ch_half_db_out(hd[d]), .ch1_level_out(raw[d][0]),
      .ch2_level_out(raw[d][1]), .ch3_level_out(raw[d][2]));
  end
  dca_link_properties #(.CHAIN_LEN(2)) dca_link_properties_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .sclk(l[0].sclk), .sdata(l[0].sdata), .strobe(l[0].strobe),
    .sdata_out(l[0].sdata_out));
  // ------
  // Tasks
  // ------
  task automatic test_done;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [7:0] hd_exp(input logic [7:0] c);
    if (c < 8'h20) return c;
    if (c < 8'h40) return 8'(c * 2 - 8'h20);
    return 8'(c * 4 - 8'ha0);
  endfunction
  task automatic send(input logic [15:0] far, input logic [15:0] near);
    int i;
    @(posedge clk_in);
    #2;
    words_in = {far, near};
    start_in = 1'b1;
    @(posedge clk_in);
    #2;
    start_in = 1'b0;
    `CK("busy", 1'b1, busy_out)
    for (i = 0; i < 1000 && done_out !== 1'b1; i++) begin
      @(posedge clk_in);
      #2;
    end
    if (i == 1000) fails++;
    `CK("busy_end", 1'b0, busy_out)
    @(posedge clk_in);
    #2;
    `CK("done_pulse", 1'b0, done_out)
    // Outputs cross from the link domain in up to four cycles
    repeat (8) @(posedge clk_in);
    if (near[15:8] < 8'h03) lvl[0][near[9:8]] = near[7:0];
    if (far[15:8] < 8'h03) lvl[1][far[9:8]] = far[7:0];
  endtask
  task automatic chk(input int d);
    for (int c = 0; c < 3; c++) begin
      `CK("level", lvl[d][c], raw[d][c])
      `CK("mute", lvl[d][c] >= 8'h4f, mu[d][c])
      if (lvl[d][c] < 8'h4f) `CK("half_db", hd_exp(lvl[d][c]), hd[d][c])
    end
  endtask
  initial begin
    foreach (lvl[d, c]) lvl[d][c] = 8'h4f;
    repeat (12) @(posedge clk_in);
    #2 rst_n_in = 1'b1;
    chk(0);
    chk(1);
    for (int i = 0; i < 8; i++) begin
      send({8'(i % 3), lv[i]}, {8'((i + 1) % 3), lv[7 - i]});
      chk(0);
      chk(1);
    end
    send({8'h03, 8'h00}, {8'hff, 8'h00});
    chk(0);
    chk(1);
    test_done();
  end
  // Nine transfers need about 2500 cycles; the limit leaves wide margin
  initial begin
    #(25 * 20000);
    fails++;
    test_done();
  end
endmodule
